// File: hw/sci_pkg.sv
package sci_pkg;

   // Command word layout
   localparam int CMD_W      = 8;
   localparam int NIB_W      = 4;
   localparam int BIT_CNT_W  = 3;
   localparam int HALF_BIT   = 4;

   localparam logic [2:0] OP_NULL     = 3'h0;
   localparam logic [2:0] OP_IRQ_EN   = 3'h1;
   localparam logic [2:0] OP_MODE     = 3'h2;
   localparam logic [2:0] OP_CLEAR    = 3'h3;
   localparam logic [2:0] OP_DEADTIME = 3'h4;

   // Mode and dead-time command data bits
   localparam int MODE_LOCK_BIT    = 0;
   localparam int MODE_OVERLAP_BIT = 1;
   localparam int MODE_DESAT_BIT   = 3;
   localparam int DT_CAL_BIT       = 0;

   // Status register 0 bit positions
   localparam int ST_THERMAL_LIMIT_FLAG    = 0;
   localparam int ST_DESAT   = 1;
   localparam int ST_UV      = 2;
   localparam int ST_OVERCUR = 3;
   localparam int ST_PHASE   = 4;
   localparam int ST_FRAME   = 5;
   localparam int ST_WRITE   = 6;
   localparam int ST_RESET   = 7;

   // Status register selectors
   localparam logic [1:0] SEL_ST0 = 2'h0;
   localparam logic [1:0] SEL_ST1 = 2'h1;
   localparam logic [1:0] SEL_ST2 = 2'h2;
   localparam logic [1:0] SEL_ST3 = 2'h3;

   // Reset values
   localparam logic [NIB_W-1:0]  IRQ_EN_RESET   = 4'hF;
   localparam logic [CMD_W-1:0]  LATCH_RESET    = 8'h80;
   localparam logic [CMD_W-1:0]  DEADTIME_RESET = 8'hFF;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 3'h1;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 3'h0;

   // Calibration pulse length is divided by sixteen
   localparam int DT_DIV_SHIFT = 4;

   typedef struct packed {
      logic [2:0] op;
      logic [4:0] data;
   } sci_cmd_t;

   typedef struct packed {
      logic desat_mode;
      logic overlap;
      logic lock;
   } sci_mode_t;

   typedef struct packed {
      logic [2:0] thermal_limit_flag;
      logic [2:0] desat;
      logic       uv;
      logic       overcur;
      logic [2:0] phase_cmp;
      logic [2:0] drive;
      logic       blank;
      logic       enable;
   } sci_faults_t;

   typedef enum logic [1:0] {
      CAL_IDLE    = 2'b00,
      CAL_ARMED   = 2'b01,
      CAL_MEASURE = 2'b10
   } sci_cal_state_t;

endpackage

// File: hw/sci_top.sv
`timescale 1ns/1ps

// Overview of operation
// - Commands are 8-bit words; only the last eight bits of a longer frame count.
// - Top three bits of the byte are the command, low five bits its data.
// - Frames not a multiple of eight bits are dropped and set framing error.
// - First response shifted out after reset is status register 0.
// - Status read changes nothing; its two low bits pick status register 0 to 3.
// - Enable commands load the low or high interrupt-enable nibble; one enables.
// - Clear commands clear low or high latch group per one bit in data nibble.
// - Mode command sets desat/phase handling, overlap-allowed mode and lock.
// - Opcode 100 starts dead-time programming and returns status register 0.
// - Every command except status reads returns status register 0 next.
// - Interrupt is signalled by driving the interrupt pin high.
// - Faults latch on occurrence; only reset or the matching clear command clears them.
// - A fault still present during a clear keeps its latch and interrupt.
// - Interrupt stays high with no low pulse while enabled faults remain.
// - Returned flags cover every fault not cleared up to this frame start.
// - A clear takes effect only for a correctly framed transfer.
// - A latch returned as zero that sets during the clear frame stays set.
// - Latch clearing is applied at the chip-select rising edge ending the frame.
// - Low enable bits: overtemperature, desaturation, supply undervoltage, overcurrent.
// - High enable bits: phase error, framing error, write after lock, reset event.
// - Phase error is comparator XOR drive, blanked in blanking and overlap mode.
// - Reset or disable sets the reset event flag, so interrupt rises at once.
// - Lock clears only on reset; later config writes are rejected, write error.
// - Calibration counts next chip-select low pulse, divides by 16, stores it.
// - Status bit 0 ORs three thermal detectors; others follow enable order.
// - Reset low clears error latches but sets the reset event, and reloads written registers.
module sci_top
   import sci_pkg::*;
#(
   parameter int CAL_CNT_W = 16
) (
   // Core clock and reset
   input  wire logic             CORE_CLK,
   input  wire logic             RST_B,
   // SPI link
   input  wire logic             SCLK,
   input  wire logic             CS_B,
   input  wire logic             SI,
   output logic                  SO,
   output logic                  SO_OE,
   // Fault sources
   input  wire logic [2:0]       THERMAL_LIMIT_FLAG,
   input  wire logic [2:0]       DESAT_DETECT,
   input  wire logic             GATE_SUPPLY_RAIL_UV,
   input  wire logic             OVERCURRENT_TRIP,
   input  wire logic [2:0]       PHASE_COMPARATOR,
   input  wire logic [2:0]       DRIVE_STATE,
   input  wire logic             DESAT_BLANKING,
   input  wire logic             DRIVER_ENABLE,
   // Interrupt and configuration outputs
   output logic                  INT,
   output logic                  DESAT_MODE,
   output logic                  OVERLAP_ALLOWED_MODE,
   output logic                  CONFIG_LOCK,
   output logic [CMD_W-1:0]      DEADTIME
);

   localparam logic [CAL_CNT_W-1:0] CAL_CNT_MAX = '1;
   localparam logic [CAL_CNT_W-1:0] CAL_CNT_ONE = CAL_CNT_W'(1);

   // ------------------------------------------------------------------
   // Link domain: SPI mode 1, SO changes on rising SCLK, SI sampled on
   // falling SCLK. Chip select high presets the frame start marker.
   // ------------------------------------------------------------------
   logic                 fresh_reg;
   logic [BIT_CNT_W-1:0] bit_cnt_reg;
   logic [BIT_CNT_W-1:0] bit_cnt_next;
   logic [CMD_W-1:0]     shift_reg;
   logic [CMD_W-1:0]     shift_next;
   logic                 frame_tgl_reg;
   logic                 so_reg;
   logic                 so_next;
   logic [CMD_W-1:0]     resp_reg;

   // The count wraps, so any multiple of eight bits ends at zero
   assign bit_cnt_next = fresh_reg ? BIT_CNT_ONE : bit_cnt_reg + BIT_CNT_ONE;
   // Shifting in behind the reply passes earlier bytes down a chain
   assign shift_next   = fresh_reg ? {resp_reg[CMD_W-2:0], SI}
                                   : {shift_reg[CMD_W-2:0], SI};
   assign so_next      = fresh_reg ? resp_reg[CMD_W-1] : shift_reg[CMD_W-1];

   always_ff @(negedge SCLK or posedge CS_B) begin
      if (CS_B) begin
         fresh_reg <= 1'b1;
      end else begin
         fresh_reg <= 1'b0;
      end
   end

   always_ff @(negedge SCLK) begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
   end

   always_ff @(posedge SCLK or posedge CS_B) begin
      if (CS_B) begin
         so_reg <= 1'b0;
      end else begin
         so_reg <= so_next;
      end
   end

   // Cleared with the core side so frame parity agrees; link clock idles in reset
   always_ff @(negedge SCLK or negedge RST_B) begin
      if (!RST_B) begin
         frame_tgl_reg <= 1'b0;
      end else if (fresh_reg) begin
         frame_tgl_reg <= ~frame_tgl_reg;
      end
   end

   assign SO = so_reg;

   // ------------------------------------------------------------------
   // Core domain synchronisers
   // ------------------------------------------------------------------
   logic        cs_meta_reg;
   logic        cs_sync_reg;
   logic        cs_prev_reg;
   logic        tgl_meta_reg;
   logic        tgl_sync_reg;
   logic        tgl_seen_reg;
   sci_faults_t flt_meta_reg;
   sci_faults_t flt_sync_reg;
   sci_faults_t flt_pins;

   assign flt_pins = '{thermal_limit_flag:      THERMAL_LIMIT_FLAG,
                       desat:     DESAT_DETECT,
                       uv:        GATE_SUPPLY_RAIL_UV,
                       overcur:   OVERCURRENT_TRIP,
                       phase_cmp: PHASE_COMPARATOR,
                       drive:     DRIVE_STATE,
                       blank:     DESAT_BLANKING,
                       enable:    DRIVER_ENABLE};

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         cs_meta_reg  <= 1'b1;
         cs_sync_reg  <= 1'b1;
         cs_prev_reg  <= 1'b1;
         tgl_meta_reg <= 1'b0;
         tgl_sync_reg <= 1'b0;
         flt_meta_reg <= '0;
         flt_sync_reg <= '0;
      end else begin
         cs_meta_reg  <= CS_B;
         cs_sync_reg  <= cs_meta_reg;
         cs_prev_reg  <= cs_sync_reg;
         tgl_meta_reg <= frame_tgl_reg;
         tgl_sync_reg <= tgl_meta_reg;
         flt_meta_reg <= flt_pins;
         flt_sync_reg <= flt_meta_reg;
      end
   end

   wire cs_fall = cs_prev_reg & ~cs_sync_reg;
   wire cs_rise = ~cs_prev_reg & cs_sync_reg;

   // ------------------------------------------------------------------
   // Frame decode at the end of chip select. The link registers are
   // static while chip select is high, so the core reads them directly
   // once the synchronised rising edge has been seen.
   // ------------------------------------------------------------------
   sci_cal_state_t cal_state_reg;
   sci_cal_state_t cal_state_next;
   sci_cmd_t       cmd;
   sci_mode_t      mode_reg;
   sci_mode_t      mode_next;

   wire got_bits   = tgl_sync_reg != tgl_seen_reg;
   wire cal_frame  = cal_state_reg == CAL_MEASURE;
   wire good_frame = cs_rise & got_bits & ~cal_frame
                     & (bit_cnt_reg == BIT_CNT_ZERO);
   wire frame_err  = cs_rise & got_bits
                     & (cal_frame | (bit_cnt_reg != BIT_CNT_ZERO));

   assign cmd = sci_cmd_t'(shift_reg);

   wire is_null    = good_frame & (cmd.op == OP_NULL);
   wire is_irq_en  = good_frame & (cmd.op == OP_IRQ_EN);
   wire is_mode    = good_frame & (cmd.op == OP_MODE);
   wire is_clear   = good_frame & (cmd.op == OP_CLEAR);
   wire is_dt      = good_frame & (cmd.op == OP_DEADTIME);
   wire hi_half    = cmd.data[HALF_BIT];
   wire cfg_write  = is_irq_en | is_mode | is_dt;
   wire cfg_ok     = cfg_write & ~mode_reg.lock;
   wire write_err  = cfg_write & mode_reg.lock;

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         tgl_seen_reg <= 1'b0;
      end else if (cs_rise) begin
         tgl_seen_reg <= tgl_sync_reg;
      end
   end

   // ------------------------------------------------------------------
   // Mode and interrupt-enable registers
   // ------------------------------------------------------------------
   logic [NIB_W-1:0] en_low_reg;
   logic [NIB_W-1:0] en_high_reg;

   // Lock is sticky: once set, a write can never lower it again
   assign mode_next = (cfg_ok & is_mode)
                      ? '{desat_mode: cmd.data[MODE_DESAT_BIT],
                          overlap:    cmd.data[MODE_OVERLAP_BIT],
                          lock:       cmd.data[MODE_LOCK_BIT]}
                      : mode_reg;

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         mode_reg    <= '0;
         en_low_reg  <= IRQ_EN_RESET;
         en_high_reg <= IRQ_EN_RESET;
      end else begin
         mode_reg <= mode_next;
         if (cfg_ok & is_irq_en & ~hi_half) begin
            en_low_reg <= cmd.data[NIB_W-1:0];
         end
         if (cfg_ok & is_irq_en & hi_half) begin
            en_high_reg <= cmd.data[NIB_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Dead-time programming
   // ------------------------------------------------------------------
   logic [CAL_CNT_W-1:0] cal_cnt_reg;
   logic [CMD_W-1:0]     deadtime_reg;
   logic [CAL_CNT_W-1:0] cal_div;

   wire dt_calibrate = cfg_ok & is_dt & cmd.data[DT_CAL_BIT];
   wire dt_zero      = cfg_ok & is_dt & ~cmd.data[DT_CAL_BIT];

   assign cal_div = cal_cnt_reg >> DT_DIV_SHIFT;

   // A long pulse saturates at the largest storable dead time
   wire [CMD_W-1:0] cal_value = (|cal_div[CAL_CNT_W-1:CMD_W])
                                ? DEADTIME_RESET : cal_div[CMD_W-1:0];

   always_comb begin
      cal_state_next = cal_state_reg;
      unique case (cal_state_reg)
         CAL_IDLE: begin
            if (dt_calibrate) begin
               cal_state_next = CAL_ARMED;
            end
         end
         CAL_ARMED: begin
            if (cs_fall) begin
               cal_state_next = CAL_MEASURE;
            end
         end
         CAL_MEASURE: begin
            if (cs_rise) begin
               cal_state_next = CAL_IDLE;
            end
         end
         default: begin
            cal_state_next = CAL_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         cal_state_reg <= CAL_IDLE;
         cal_cnt_reg   <= '0;
         deadtime_reg  <= DEADTIME_RESET;
      end else begin
         cal_state_reg <= cal_state_next;
         if (cal_state_reg == CAL_ARMED) begin
            cal_cnt_reg <= '0;
         end else if (cal_frame & ~cs_rise & (cal_cnt_reg != CAL_CNT_MAX)) begin
            cal_cnt_reg <= cal_cnt_reg + CAL_CNT_ONE;
         end
         if (cal_frame & cs_rise) begin
            deadtime_reg <= cal_value;
         end else if (dt_zero) begin
            deadtime_reg <= '0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Fault latches
   // ------------------------------------------------------------------
   logic [CMD_W-1:0] latch_reg;
   logic [CMD_W-1:0] latch_next;
   logic [CMD_W-1:0] snap_reg;
   logic [CMD_W-1:0] fault_now;
   logic [CMD_W-1:0] clear_req;
   logic [CMD_W-1:0] clear_eff;
   logic             enable_prev_reg;

   wire phase_err = |(flt_sync_reg.phase_cmp ^ flt_sync_reg.drive)
                    & ~flt_sync_reg.blank & ~mode_reg.overlap;
   wire disable_ev = enable_prev_reg & ~flt_sync_reg.enable;

   always_comb begin
      fault_now           = '0;
      fault_now[ST_THERMAL_LIMIT_FLAG]    = |flt_sync_reg.thermal_limit_flag;
      fault_now[ST_DESAT]   = |flt_sync_reg.desat;
      fault_now[ST_UV]      = flt_sync_reg.uv;
      fault_now[ST_OVERCUR] = flt_sync_reg.overcur;
      fault_now[ST_PHASE]   = phase_err;
      fault_now[ST_FRAME]   = frame_err;
      fault_now[ST_WRITE]   = write_err;
      fault_now[ST_RESET]   = disable_ev;
   end

   assign clear_req = !is_clear ? '0
                    : hi_half  ? {cmd.data[NIB_W-1:0], {NIB_W{1'b0}}}
                               : {{NIB_W{1'b0}}, cmd.data[NIB_W-1:0]};
   // Only bits seen set at the start of the clear frame may go; a fault
   // that appeared later has not been observed by the host
   assign clear_eff  = clear_req & snap_reg;
   // A live fault re-sets its latch in the same cycle as the clear
   assign latch_next = (latch_reg & ~clear_eff) | fault_now;

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         latch_reg       <= LATCH_RESET;
         snap_reg        <= '0;
         enable_prev_reg <= 1'b0;
      end else begin
         latch_reg       <= latch_next;
         enable_prev_reg <= flt_sync_reg.enable;
         if (cs_fall) begin
            snap_reg <= latch_reg;
         end
      end
   end

   // ------------------------------------------------------------------
   // Response word, chosen by the previous command, frozen at frame start
   // ------------------------------------------------------------------
   logic [1:0]       sel_reg;
   logic [CMD_W-1:0] status_sel;
   logic [CMD_W-1:0] status1;

   assign status1 = {{(CMD_W-3){1'b0}}, mode_reg};

   always_comb begin
      unique case (sel_reg)
         SEL_ST0: status_sel = latch_reg;
         SEL_ST1: status_sel = status1;
         SEL_ST2: status_sel = {en_high_reg, en_low_reg};
         SEL_ST3: status_sel = deadtime_reg;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         sel_reg  <= SEL_ST0;
         resp_reg <= '0;
      end else begin
         if (is_null) begin
            sel_reg <= cmd.data[1:0];
         end else if (good_frame) begin
            sel_reg <= SEL_ST0;
         end
         if (cs_fall) begin
            resp_reg <= status_sel;
         end
      end
   end

   // ------------------------------------------------------------------
   // Interrupt and registered outputs
   // ------------------------------------------------------------------
   wire [CMD_W-1:0] irq_en  = {en_high_reg, en_low_reg};
   // Level output: any enabled latch holds it high, so clearing one of
   // several pending faults never produces a low pulse
   wire             irq_any = |(latch_next & irq_en);

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         INT                  <= 1'b0;
         SO_OE                <= 1'b0;
         DESAT_MODE           <= 1'b0;
         OVERLAP_ALLOWED_MODE <= 1'b0;
         CONFIG_LOCK          <= 1'b0;
         DEADTIME             <= DEADTIME_RESET;
      end else begin
         INT                  <= irq_any;
         SO_OE                <= ~cs_sync_reg;
         DESAT_MODE           <= mode_reg.desat_mode;
         OVERLAP_ALLOWED_MODE <= mode_reg.overlap;
         CONFIG_LOCK          <= mode_reg.lock;
         DEADTIME             <= deadtime_reg;
      end
   end

endmodule

// File: sim/sci_host_model.sv
`timescale 1ns/1ps
module sci_host_model (
   // SPI master side
   output logic      sclk,
   output logic      cs_b,
   output logic      si,
   input  wire logic so
);
   initial begin
      sclk = 1'b0;
      cs_b = 1'b0;
      si   = 1'b0;
      // One definite rise of select presets the link frame marker
      #1;
      cs_b = 1'b1;
   end
   // SI moves on the rising edge, SO is taken on the falling edge
   task automatic frame(input int n, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      cs_b = 1'b0;
      // Core needs the select before the first clock to snapshot its reply
      #40;
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b1;
         si = tx[i];
         #7.5;
         sclk = 1'b0;
         rx = {rx[14:0], so};
         #7.5;
      end
      // Clock parks low and the data line falls to its pull-down level
      si = 1'b0;
      cs_b = 1'b1;
      #64;
   endtask
   // Select pulse without clocks, measured by the dead-time calibration
   task automatic pulse(input int len);
      cs_b = 1'b0;
      #(len);
      cs_b = 1'b1;
      #64;
   endtask
endmodule

// File: sim/sci_checker.sv
`timescale 1ns/1ps
module sci_checker
   import sci_pkg::*;
#(
   parameter int CAL_CNT_W = 16
) (
   // Clock and reset
   input wire logic             CORE_CLK,
   input wire logic             RST_B,
   // Link pins
   input wire logic             CS_B,
   input wire logic             SO_OE,
   // Status and configuration
   input wire logic             INT,
   input wire logic             DESAT_MODE,
   input wire logic             OVERLAP_ALLOWED_MODE,
   input wire logic             CONFIG_LOCK,
   input wire logic [CMD_W-1:0] DEADTIME
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   chk_reset_values: assert property (
      $rose(RST_B) |-> !INT && !CONFIG_LOCK && !DESAT_MODE && !OVERLAP_ALLOWED_MODE
         && DEADTIME == DEADTIME_RESET)
      else $error("reset values wrong");
   chk_int_at_start: assert property ($rose(RST_B) |-> ##[1:3] INT)
      else $error("no interrupt after reset");
   chk_lock_holds: assert property (CONFIG_LOCK |=> CONFIG_LOCK)
      else $error("lock dropped");
   chk_locked_config: assert property (
      CONFIG_LOCK |=> $stable(DESAT_MODE) && $stable(OVERLAP_ALLOWED_MODE) && $stable(DEADTIME))
      else $error("configuration changed while locked");
   chk_cfg_quiet_low: assert property (
      (!CS_B) [*5] |-> $stable(DEADTIME) && $stable(CONFIG_LOCK) && $stable(DESAT_MODE)
         && $stable(OVERLAP_ALLOWED_MODE))
      else $error("configuration changed inside a frame");
   chk_int_clear_edge: assert property ($fell(INT) |-> $past(CS_B, 2))
      else $error("interrupt dropped while selected");
   chk_oe_on: assert property ((!CS_B) [*4] |-> SO_OE)
      else $error("reply not driven");
   chk_oe_off: assert property (CS_B [*4] |-> !SO_OE)
      else $error("reply driven while idle");

   cover property ($rose(INT));
   cover property ($fell(INT));
   cover property ($rose(CONFIG_LOCK));
   cover property ($changed(DEADTIME));
endmodule

bind sci_top sci_checker #(.CAL_CNT_W(CAL_CNT_W)) chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
   .CS_B(CS_B), .SO_OE(SO_OE), .INT(INT), .DESAT_MODE(DESAT_MODE),
   .OVERLAP_ALLOWED_MODE(OVERLAP_ALLOWED_MODE), .CONFIG_LOCK(CONFIG_LOCK), .DEADTIME(DEADTIME));

// File: sim/sci_top_test.sv
`timescale 1ns/1ps
module sci_top_test;
   import sci_pkg::*;
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] resp;
      logic       irq;
      sci_mode_t  mode;
   } sci_row_t;
   logic             core_clk = 1'b0;
   logic             rst_b    = 1'b1;
   logic [2:0]       thermal_limit_flag     = 3'h0;
   logic [2:0]       desat    = 3'h0;
   logic [2:0]       phase    = 3'h0;
   logic [2:0]       drive    = 3'h0;
   logic             uv       = 1'b0;
   logic             ovc      = 1'b0;
   logic             blank    = 1'b0;
   logic             drv_en   = 1'b1;
   wire              sclk, cs_b, si;
   logic             so, so_oe, irq, desat_mode, overlap, lock;
   logic [CMD_W-1:0] deadtime;
   logic [15:0]      rx;
   int               miscompares = 0;
   int               n_tests     = 0;
   // Reply seen in each frame belongs to the command of the frame before
   sci_row_t         rows [11] = '{
      '{8'h00, 8'h80, 1'b1, 3'h0}, '{8'h78, 8'h80, 1'b0, 3'h0}, '{8'h01, 8'h00, 1'b0, 3'h0},
      '{8'h02, 8'h00, 1'b0, 3'h0}, '{8'h03, 8'hFF, 1'b0, 3'h0}, '{8'h20, 8'hFF, 1'b0, 3'h0},
      '{8'h3E, 8'h00, 1'b0, 3'h0}, '{8'h4A, 8'h00, 1'b0, 3'h6}, '{8'h01, 8'h00, 1'b0, 3'h6},
      '{8'h02, 8'h06, 1'b0, 3'h6}, '{8'h00, 8'hE0, 1'b0, 3'h6}};

   always #4 core_clk = ~core_clk;

   sci_host_model host (.sclk(sclk), .cs_b(cs_b), .si(si), .so(so));
   sci_top #(.CAL_CNT_W(16)) uut (
      .CORE_CLK(core_clk), .RST_B(rst_b), .SCLK(sclk), .CS_B(cs_b), .SI(si), .SO(so),
      .SO_OE(so_oe), .THERMAL_LIMIT_FLAG(thermal_limit_flag), .DESAT_DETECT(desat),
      .GATE_SUPPLY_RAIL_UV(uv), .OVERCURRENT_TRIP(ovc), .PHASE_COMPARATOR(phase),
      .DRIVE_STATE(drive), .DESAT_BLANKING(blank), .DRIVER_ENABLE(drv_en), .INT(irq),
      .DESAT_MODE(desat_mode), .OVERLAP_ALLOWED_MODE(overlap), .CONFIG_LOCK(lock),
      .DEADTIME(deadtime));

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_byte(what, {7'h00, exp}, {7'h00, got});
   endtask
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] exp);
      host.frame(8, {8'h00, cmd}, rx);
      chk_byte("reply", exp, rx[7:0]);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #100000;
      miscompares++;
      test_done();
   end

   initial begin
      // A definite falling edge clears the link-side frame toggle
      #1;
      rst_b = 1'b0;
      tick(10);
      rst_b = 1'b1;
      tick(3);
      chk_bit("irq", 1'b1, irq);
      foreach (rows[i]) begin
         xfer(rows[i].cmd, rows[i].resp);
         chk_bit("irq", rows[i].irq, irq);
         chk_byte("mode", {5'h00, rows[i].mode}, {5'h00, desat_mode, overlap, lock});
      end
      // Masked faults latch without raising the interrupt
      for (int k = 0; k < 4; k++) begin
         {thermal_limit_flag[2], desat[0], uv, ovc} = 4'h8 >> k;
         tick(6);
         {thermal_limit_flag[2], desat[0], uv, ovc} = 4'h0;
         tick(6);
         chk_bit("irq", 1'b0, irq);
         xfer(8'h00, 8'h01 << k);
         xfer({4'h6, 4'h1 << k}, 8'h01 << k);
         xfer(8'h00, 8'h00);
      end
      xfer(8'h28, 8'h00);
      ovc = 1'b1;
      tick(6);
      chk_bit("irq", 1'b1, irq);
      xfer(8'h68, 8'h08);
      chk_bit("irq", 1'b1, irq);
      ovc = 1'b0;
      tick(6);
      chk_bit("irq", 1'b1, irq);
      xfer(8'h68, 8'h08);
      chk_bit("irq", 1'b0, irq);
      fork
         xfer(8'h68, 8'h00);
         begin
            tick(12);
            ovc = 1'b1;
            tick(4);
            ovc = 1'b0;
         end
      join
      chk_bit("irq", 1'b1, irq);
      host.frame(9, 16'h0068, rx);
      tick(1);
      xfer(8'h00, 8'h28);
      xfer(8'h72, 8'h28);
      xfer(8'h68, 8'h08);
      chk_bit("irq", 1'b0, irq);
      host.frame(16, 16'h602F, rx);
      chk_byte("chain lead", 8'h00, rx[15:8]);
      chk_byte("chain pass", 8'h60, rx[7:0]);
      xfer(8'h02, 8'h00);
      xfer(8'h00, 8'hEF);
      phase = 3'h1;
      tick(6);
      phase = 3'h0;
      tick(4);
      xfer(8'h48, 8'h00);
      blank = 1'b1;
      phase = 3'h4;
      tick(6);
      phase = 3'h0;
      tick(2);
      blank = 1'b0;
      tick(4);
      xfer(8'h00, 8'h00);
      phase = 3'h2;
      tick(6);
      phase = 3'h0;
      tick(4);
      xfer(8'h00, 8'h10);
      xfer(8'h71, 8'h10);
      chk_bit("irq", 1'b0, irq);
      xfer(8'h80, 8'h00);
      chk_byte("deadtime", 8'h00, deadtime);
      xfer(8'h81, 8'h00);
      host.pulse(1600);
      chk_byte("deadtime", 8'h0C, deadtime);
      xfer(8'h4B, 8'h00);
      chk_bit("lock", 1'b1, lock);
      xfer(8'h20, 8'h00);
      chk_bit("irq", 1'b1, irq);
      xfer(8'h80, 8'h40);
      chk_byte("deadtime", 8'h0C, deadtime);
      xfer(8'h02, 8'h40);
      xfer(8'h00, 8'hEF);
      rst_b = 1'b0;
      tick(10);
      chk_byte("reset", 8'h00, {4'h0, irq, lock, desat_mode, overlap});
      chk_byte("deadtime", 8'hFF, deadtime);
      rst_b = 1'b1;
      tick(3);
      chk_bit("irq", 1'b1, irq);
      xfer(8'h78, 8'h80);
      chk_bit("irq", 1'b0, irq);
      drv_en = 1'b0;
      tick(6);
      drv_en = 1'b1;
      chk_bit("irq", 1'b1, irq);
      test_done();
   end
endmodule
